// >>> hdl/bit_toggle_branch_call_exec.sv
// Executes bit toggle, overflow and zero branches, bit skips and the call.
// Assumes the core presents the instruction at phase one with its address in pc_i.
// Data memory reads are combinational from dmem_addr_o.
`timescale 1ns/1ps
module bit_toggle_branch_call_exec
	import exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [15:0] instr_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic next_two_word_i,
	input wire logic flag_ov_i,
	input wire logic flag_z_i,
	input wire logic ext_en_i,
	input wire logic [ADDR_W-1:0] index_base_i,
	input wire ctx_t ctx_i,
	input wire logic [7:0] dmem_rdata_i,
	output logic [ADDR_W-1:0] dmem_addr_o,
	output dmem_wr_t dmem_wr_o,
	output logic pc_we_o,
	output logic [PC_W-1:0] pc_new_o,
	output logic push_o,
	output logic [PC_W-1:0] return_stack_top_o,
	output logic shadow_we_o,
	output ctx_t shadow_o,
	output logic idle_o,
	output logic cycle_end_o
);
	typedef struct packed {
		mode_t mode;
		logic [1:0] idle_left;
		logic [7:0] lit_lo;
		logic shadow_sel;
		logic [7:0] data;
		dmem_wr_t wr;
		logic pc_we;
		logic [PC_W-1:0] pc_new;
		logic push;
		logic [PC_W-1:0] return_stack_top;
		logic shadow_we;
		ctx_t shadow;
	} state_t;

	state_t st;
	state_t next_st;
	phase_t phase;
	logic [ADDR_W-1:0] addr;

	function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc, input logic [7:0] n);
		logic [PC_W-1:0] off;
		off = {{(PC_W-9){n[7]}}, n, 1'b0};
		branch_target = pc + PC_STEP + off;
	endfunction : branch_target

	phase_gen u_phase (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.phase_o(phase)
	);

	addr_form u_addr (
		.f_i(instr_i[7:0]),
		.access_i(instr_i[8]),
		.bsr_i(ctx_i.bank_select_register),
		.ext_en_i(ext_en_i),
		.index_base_i(index_base_i),
		.addr_o(addr)
	);

	wire logic is_toggle = instr_i[15:12] == OPC_TOGGLE; // RULE_02
	wire logic is_skip = instr_i[15:12] == OPC_SKIP_CLR || instr_i[15:12] == OPC_SKIP_SET;
	wire logic is_bov = instr_i[15:8] == OPC_BR_OV; // RULE_07
	wire logic is_bz = instr_i[15:8] == OPC_BR_Z; // RULE_09
	wire logic is_call = instr_i[15:9] == OPC_CALL;
	wire logic bit_val = dmem_rdata_i[instr_i[11:9]];
	wire logic run_phase = st.mode == RUN;

	always_comb begin
		next_st = st;
		next_st.wr.we = 1'b0;
		next_st.pc_we = 1'b0;
		next_st.push = 1'b0;
		next_st.shadow_we = 1'b0;
		case (st.mode)
			RUN: begin
				case (phase)
					Q2: begin
						next_st.data = dmem_rdata_i; // RULE_05
						next_st.lit_lo = instr_i[7:0];
						next_st.shadow_sel = instr_i[8];
					end
					Q3: begin
						if (is_toggle) begin
							next_st.data = st.data ^ (8'h01 << instr_i[11:9]); // RULE_01
						end
						if (is_call) begin
							next_st.push = 1'b1; // RULE_12
							next_st.return_stack_top = pc_i + CALL_RET_STEP; // RULE_12
							next_st.shadow_we = st.shadow_sel; // RULE_13 RULE_14
							next_st.shadow = ctx_i; // RULE_13
						end
					end
					Q4: begin
						if (is_toggle) begin
							next_st.wr.we = 1'b1; // RULE_05
							next_st.wr.addr = addr;
							next_st.wr.wdata = st.data;
						end
						if ((is_bov && flag_ov_i) || (is_bz && flag_z_i)) begin // RULE_06 RULE_08
							next_st.pc_we = 1'b1; // RULE_11
							next_st.pc_new = branch_target(pc_i, instr_i[7:0]); // RULE_10
							next_st.mode = IDLE; // RULE_11
							next_st.idle_left = 2'd1;
						end
						// Bit 12 set means skip on a clear bit, so the sense is inverted
						if (is_skip && (bit_val != instr_i[12])) begin
							next_st.mode = IDLE; // RULE_15
							next_st.idle_left = next_two_word_i ? 2'd2 : 2'd1; // RULE_15
						end
						if (is_call) begin
							next_st.mode = CALL2; // RULE_14
						end
					end
					default: begin
					end
				endcase
			end
			CALL2: begin
				if (phase == Q4) begin
					next_st.pc_we = 1'b1; // RULE_12
					next_st.pc_new = {instr_i[11:0], st.lit_lo, 1'b0}; // RULE_12 RULE_14
					next_st.mode = RUN;
				end
			end
			IDLE: begin
				if (phase == Q4) begin
					next_st.idle_left = st.idle_left - 2'd1;
					if (st.idle_left == 2'd1) begin
						next_st.mode = RUN;
					end
				end
			end
			default: begin
				next_st.mode = RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dmem_addr_o = addr;
	assign dmem_wr_o = st.wr;
	assign pc_we_o = st.pc_we;
	assign pc_new_o = st.pc_new;
	assign push_o = st.push;
	assign return_stack_top_o = st.return_stack_top;
	assign shadow_we_o = st.shadow_we;
	assign shadow_o = st.shadow;
	assign idle_o = !run_phase;
	assign cycle_end_o = phase == Q4;
endmodule : bit_toggle_branch_call_exec

// >>> hdl/exec_pkg.sv
// Constants and carriers for the bit-toggle, branch and call execution block.
// Assumes a single 200 MHz clock with four phases per instruction cycle.
// Contract
// RULE_01: Bit toggle inverts only the chosen bit of the addressed byte.
// RULE_02: Bit toggle is opcode nibble 0111 with bit index, access bit and address, and leaves flags alone.
// RULE_03: Access bit 0 picks the access bank, access bit 1 uses the bank select register.
// RULE_04: With the extended set on and access bit 0, addresses up to 95 use indexed literal offset mode.
// RULE_05: Bit toggle takes one cycle: decode, read, process, write back.
// RULE_06: Branch on overflow loads the program counter only when overflow is 1.
// RULE_07: Branch on overflow is upper byte 1110 0100 with a signed offset and leaves flags alone.
// RULE_08: Branch on zero loads the program counter only when zero is 1.
// RULE_09: Branch on zero is upper byte 1110 0000 with a signed offset and leaves flags alone.
// RULE_10: A taken branch goes to the incremented counter plus twice the signed offset.
// RULE_11: A branch takes one cycle untaken, two taken, with the counter written in phase four.
// RULE_12: A call pushes counter plus 4 and loads the 20-bit literal into counter bits 20 to 1.
// RULE_13: With the shadow flag set, a call copies working, status and bank select into shadows.
// RULE_14: A call is two words and two cycles, the second word giving literal bits 19 to 8.
// RULE_15: A met skip condition discards the next instruction with idle cycles, one more if it is two words.
package exec_pkg;
	localparam int PC_W = 21;
	localparam int ADDR_W = 12;
	localparam logic [3:0] OPC_TOGGLE = 4'h7;
	localparam logic [3:0] OPC_SKIP_CLR = 4'hb;
	localparam logic [3:0] OPC_SKIP_SET = 4'ha;
	localparam logic [7:0] OPC_BR_OV = 8'he4;
	localparam logic [7:0] OPC_BR_Z = 8'he0;
	localparam logic [6:0] OPC_CALL = 7'h76;
	localparam logic [3:0] OPC_SECOND = 4'hf;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h000004;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam int PHASES = 4;
	typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b11, Q4 = 2'b10} phase_t;
	typedef enum logic [1:0] {RUN = 2'b00, IDLE = 2'b01, CALL2 = 2'b11} mode_t;
	typedef struct packed {
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] bank_select_register;
	} ctx_t;
	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} dmem_wr_t;
endpackage : exec_pkg

// >>> hdl/phase_gen.sv
// Four-phase instruction cycle generator.
// Assumes one clock; each phase lasts one clock cycle.
`timescale 1ns/1ps
module phase_gen
	import exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	output phase_t phase_o
);
	phase_t phase;
	phase_t next_phase;
	always_comb begin
		case (phase)
			Q1: next_phase = Q2;
			Q2: next_phase = Q3;
			Q3: next_phase = Q4;
			Q4: next_phase = Q1;
			default: next_phase = Q1;
		endcase
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase <= Q1;
		end else begin
			phase <= next_phase;
		end
	end
	assign phase_o = phase;
endmodule : phase_gen

// >>> hdl/addr_form.sv
// Forms the data-memory address of a register operand.
// Assumes the indexed base is supplied by the core's index register.
`timescale 1ns/1ps
module addr_form
	import exec_pkg::*;
(
	input wire logic [7:0] f_i,
	input wire logic access_i,
	input wire logic [7:0] bsr_i,
	input wire logic ext_en_i,
	input wire logic [ADDR_W-1:0] index_base_i,
	output logic [ADDR_W-1:0] addr_o
);
	always_comb begin
		if (access_i) begin
			addr_o = {bsr_i[3:0], f_i}; // RULE_03
		end else if (ext_en_i && f_i <= INDEXED_LIMIT) begin
			addr_o = index_base_i + {4'h0, f_i}; // RULE_04
		end else if (f_i < ACCESS_SPLIT) begin
			addr_o = {4'h0, f_i}; // RULE_03
		end else begin
			addr_o = {ACCESS_HIGH_BANK, f_i};
		end
	end
endmodule : addr_form

// >>> tb/exec_chk.sv
// Port checker for the execution block.
// Assumes a bind from tb.
`timescale 1ns/1ps
module exec_chk
	import exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire ctx_t ctx_i,
	input wire logic [7:0] dmem_rdata_i,
	input wire dmem_wr_t dmem_wr_o,
	input wire logic pc_we_o,
	input wire logic [PC_W-1:0] pc_new_o,
	input wire logic push_o,
	input wire logic [PC_W-1:0] return_stack_top_o,
	input wire logic shadow_we_o,
	input wire ctx_t shadow_o,
	input wire logic idle_o,
	input wire logic cycle_end_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_one_bit: assert property (dmem_wr_o.we |-> $onehot(dmem_wr_o.wdata ^ $past(dmem_rdata_i, 3)))
		else $error("toggle bits");
	a_we_after: assert property (dmem_wr_o.we |-> $past(cycle_end_o) ##1 !dmem_wr_o.we)
		else $error("write slot");
	a_pcwe_after: assert property (pc_we_o |-> $past(cycle_end_o) ##1 !pc_we_o)
		else $error("pc write slot");
	a_pc_even: assert property (pc_we_o |-> !pc_new_o[0])
		else $error("odd pc");
	a_push_ret: assert property (push_o |-> cycle_end_o && return_stack_top_o == pc_i + CALL_RET_STEP)
		else $error("return address");
	a_shadow_copy: assert property (shadow_we_o |-> push_o && shadow_o == ctx_i)
		else $error("shadow copy");
	a_cycle_len: assert property (cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o)
		else $error("cycle length");
	a_idle_quiet: assert property (idle_o |-> !dmem_wr_o.we && !push_o)
		else $error("idle activity");
endmodule : exec_chk

// >>> tb/tb.sv
// Bench for the execution block.
// Assumes inputs move 1 ns after a rising edge.
`timescale 1ns/1ps
module tb
	import exec_pkg::*;
;
	logic clk_i = 0, rstn_i = 0, next_two_word_i = 0, flag_ov_i = 0, flag_z_i = 0, ext_en_i = 0;
	logic [15:0] instr_i = 16'h0000;
	logic [PC_W-1:0] pc_i = 21'h000100, pc_new_o, return_stack_top_o;
	logic [ADDR_W-1:0] index_base_i = 12'h100, dmem_addr_o;
	ctx_t ctx_i = 24'ha53c03, shadow_o;
	logic [7:0] dmem_rdata_i = 8'h75;
	dmem_wr_t dmem_wr_o;
	logic pc_we_o, push_o, shadow_we_o, idle_o, cycle_end_o, g_idle, g_push, g_shw, g_pcwe;
	int num_errors = 0, checked = 0, cycles = 0;
	// Each entry: ext, word, address
	logic [31:0] at [6] = '{32'h07325325, 32'h07270f70, 32'h07210010, 32'h1725f15f, 32'h17260f60, 32'h17310310};
	logic [15:0] bw [4] = '{16'he4fe, 16'he47f, 16'he080, 16'he002};
	bit_toggle_branch_call_exec dut (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i), .pc_i(pc_i),
		.next_two_word_i(next_two_word_i), .flag_ov_i(flag_ov_i), .flag_z_i(flag_z_i), .ext_en_i(ext_en_i),
		.index_base_i(index_base_i), .ctx_i(ctx_i), .dmem_rdata_i(dmem_rdata_i), .dmem_addr_o(dmem_addr_o),
		.dmem_wr_o(dmem_wr_o), .pc_we_o(pc_we_o), .pc_new_o(pc_new_o), .push_o(push_o),
		.return_stack_top_o(return_stack_top_o), .shadow_we_o(shadow_we_o), .shadow_o(shadow_o),
		.idle_o(idle_o), .cycle_end_o(cycle_end_o));
	always #2.5 clk_i = ~clk_i;
	task summarize();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Runs one instruction cycle; returns just after the next cycle's first edge
	task step(input logic [15:0] w);
		int n;
		instr_i = w;
		g_idle = idle_o;
		{g_push, g_shw, n} = 0;
		while (cycle_end_o !== 1'b1 && n < 8) begin
			@(posedge clk_i);
			#1;
			g_push |= push_o;
			g_shw |= shadow_we_o;
			n++;
		end
		@(posedge clk_i);
		#1;
		g_pcwe = pc_we_o;
	endtask : step
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		#1 rstn_i = 1;
		@(posedge clk_i);
		#1;
		for (int i = 0; i < 6; i++) begin
			ext_en_i = at[i][28];
			instr_i = at[i][27:12];
			#1 chk("addr", at[i][11:0], dmem_addr_o);
			step(at[i][27:12]);
			chk("wr", {1'b1, at[i][11:0]}, {dmem_wr_o.we, dmem_wr_o.addr});
		end
		for (int b = 0; b < 8; b++) begin
			step({4'h7, b[2:0], 9'h125});
			chk("wdata", 8'h75 ^ (8'h01 << b), dmem_wr_o.wdata);
		end
		for (int i = 0; i < 8; i++) begin
			flag_ov_i = i[0] ~^ bw[i/2][10];
			flag_z_i = ~flag_ov_i;
			step(bw[i/2]);
			chk("pc_we", i[0], g_pcwe);
			if (i[0]) chk("pc_new", 21'(pc_i + 21'h2 + {{12{bw[i/2][7]}}, bw[i/2][7:0], 1'b0}), pc_new_o);
			step(16'h0000);
			chk("idle", i[0], g_idle);
		end
		pc_i = 21'h000200;
		for (int s = 0; s < 2; s++) begin
			step({7'h76, s[0], 8'h34});
			chk("push", {1'b1, s[0], 21'h000204}, {g_push, g_shw, return_stack_top_o});
			if (s) chk("shadow", 24'ha53c03, shadow_o);
			step(16'hf9ab);
			chk("call", {2'b11, 21'h135668}, {g_idle, g_pcwe, pc_new_o});
		end
		for (int k = 0; k < 3; k++) begin
			next_two_word_i = (k == 0);
			step(k == 0 ? 16'ha025 : k == 1 ? 16'hb225 : 16'ha225);
			step(16'h0000);
			chk("skip1", k < 2, g_idle);
			step(16'h0000);
			chk("skip2", k == 0, g_idle);
		end
		summarize();
	end
endmodule : tb
bind bit_toggle_branch_call_exec exec_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .pc_i(pc_i), .ctx_i(ctx_i),
	.dmem_rdata_i(dmem_rdata_i), .dmem_wr_o(dmem_wr_o), .pc_we_o(pc_we_o), .pc_new_o(pc_new_o), .push_o(push_o),
	.return_stack_top_o(return_stack_top_o), .shadow_we_o(shadow_we_o), .shadow_o(shadow_o), .idle_o(idle_o),
	.cycle_end_o(cycle_end_o));
